/* File: bstl_defs.svh */
// Constants of the boundary-scan test logic
`ifndef BSTL_DEFS_SVH
`define BSTL_DEFS_SVH

`define BSTL_CHAIN_LEN 75
`define BSTL_IR_WIDTH 3
`define BSTL_IR_EXTEST 3'h0
`define BSTL_IR_SAMPLE 3'h1
`define BSTL_IR_HIGHZ 3'h5
`define BSTL_IR_CONTINUITY 3'h6
`define BSTL_IR_BYPASS 3'h7
`define BSTL_IR_CAPTURE 3'h1
`define BSTL_OE_GROUPS 9
`define BSTL_TMS_RESET_COUNT 3'h5

// Chain positions of the output-enable cells, counted from the cell next to tdi
`define BSTL_CELL_AD_OE 7'h05
`define BSTL_CELL_CBE_OE 7'h0E
`define BSTL_CELL_FRAME_OE 7'h1A
`define BSTL_CELL_IRDY_OE 7'h1C
`define BSTL_CELL_TRDY_OE 7'h1E
`define BSTL_CELL_DEVSEL_OE 7'h20
`define BSTL_CELL_STOP_OE 7'h22
`define BSTL_CELL_PERR_OE 7'h24
`define BSTL_CELL_PAR_OE 7'h27

`endif

/* File: bstl_pkg.sv */
// Types of the boundary-scan test logic
`include "bstl_defs.svh"
`default_nettype none

package bstl_pkg;

  typedef enum logic [3:0] {
    BSTL_EX2DR = 4'h0,
    BSTL_EX1DR = 4'h1,
    BSTL_SHDR = 4'h2,
    BSTL_PDR = 4'h3,
    BSTL_SELIR = 4'h4,
    BSTL_UPDR = 4'h5,
    BSTL_CAPDR = 4'h6,
    BSTL_SELDR = 4'h7,
    BSTL_EX2IR = 4'h8,
    BSTL_EX1IR = 4'h9,
    BSTL_SHIR = 4'hA,
    BSTL_PIR = 4'hB,
    BSTL_RTI = 4'hC,
    BSTL_UPIR = 4'hD,
    BSTL_CAPIR = 4'hE,
    BSTL_TLR = 4'hF
  } bstl_tap_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstl_link_s;

  typedef struct packed {
    bstl_tap_e tap;
    logic [2:0] ones_cnt;
  } bstl_tap_s;

  typedef struct packed {
    bstl_link_s sync1;
    bstl_link_s sync2;
    logic tck_prev;
    logic [`BSTL_CHAIN_LEN-1:0] chain;
    logic [`BSTL_CHAIN_LEN-1:0] upd;
    logic [`BSTL_IR_WIDTH-1:0] ir_sr;
    logic [`BSTL_IR_WIDTH-1:0] instruction_code;
    logic byp;
    logic tdo;
    logic tdo_oe;
  } bstl_core_s;

endpackage

`default_nettype wire

/* File: bstl_tap_fsm.sv */
// Test access port state machine
`include "bstl_defs.svh"
`default_nettype none

module bstl_tap_fsm (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Sampled link
  input wire logic tck_rise_i,
  input wire logic tms_i,
  // State
  output bstl_pkg::bstl_tap_e state_o
);

  bstl_pkg::bstl_tap_s tap_reg;
  bstl_pkg::bstl_tap_s tap_next;

  function automatic bstl_pkg::bstl_tap_e tap_step(input bstl_pkg::bstl_tap_e s, input logic tms);
    case (s)
      bstl_pkg::BSTL_TLR: tap_step = tms ? bstl_pkg::BSTL_TLR : bstl_pkg::BSTL_RTI;
      bstl_pkg::BSTL_RTI: tap_step = tms ? bstl_pkg::BSTL_SELDR : bstl_pkg::BSTL_RTI;
      bstl_pkg::BSTL_SELDR: tap_step = tms ? bstl_pkg::BSTL_SELIR : bstl_pkg::BSTL_CAPDR;
      bstl_pkg::BSTL_CAPDR: tap_step = tms ? bstl_pkg::BSTL_EX1DR : bstl_pkg::BSTL_SHDR;
      bstl_pkg::BSTL_SHDR: tap_step = tms ? bstl_pkg::BSTL_EX1DR : bstl_pkg::BSTL_SHDR;
      bstl_pkg::BSTL_EX1DR: tap_step = tms ? bstl_pkg::BSTL_UPDR : bstl_pkg::BSTL_PDR;
      bstl_pkg::BSTL_PDR: tap_step = tms ? bstl_pkg::BSTL_EX2DR : bstl_pkg::BSTL_PDR;
      bstl_pkg::BSTL_EX2DR: tap_step = tms ? bstl_pkg::BSTL_UPDR : bstl_pkg::BSTL_SHDR;
      bstl_pkg::BSTL_UPDR: tap_step = tms ? bstl_pkg::BSTL_SELDR : bstl_pkg::BSTL_RTI;
      bstl_pkg::BSTL_SELIR: tap_step = tms ? bstl_pkg::BSTL_TLR : bstl_pkg::BSTL_CAPIR;
      bstl_pkg::BSTL_CAPIR: tap_step = tms ? bstl_pkg::BSTL_EX1IR : bstl_pkg::BSTL_SHIR;
      bstl_pkg::BSTL_SHIR: tap_step = tms ? bstl_pkg::BSTL_EX1IR : bstl_pkg::BSTL_SHIR;
      bstl_pkg::BSTL_EX1IR: tap_step = tms ? bstl_pkg::BSTL_UPIR : bstl_pkg::BSTL_PIR;
      bstl_pkg::BSTL_PIR: tap_step = tms ? bstl_pkg::BSTL_EX2IR : bstl_pkg::BSTL_PIR;
      bstl_pkg::BSTL_EX2IR: tap_step = tms ? bstl_pkg::BSTL_UPIR : bstl_pkg::BSTL_SHIR;
      default: tap_step = tms ? bstl_pkg::BSTL_SELDR : bstl_pkg::BSTL_RTI;
    endcase
  endfunction

  // Advance once per test clock rising edge
  always_comb
  begin
    tap_next = tap_reg;
    if (tck_rise_i)
    begin
      tap_next.tap = tap_step(tap_reg.tap, tms_i);
      // Counts consecutive test clock edges with tms high
      if (!tms_i)
      begin
        tap_next.ones_cnt = 3'h0;
      end
      else if (tap_reg.ones_cnt != `BSTL_TMS_RESET_COUNT)
      begin
        tap_next.ones_cnt = tap_reg.ones_cnt + 3'h1;
      end
    end
  end

  // Power-up reset lands in the reset state
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      tap_reg.tap <= bstl_pkg::BSTL_TLR;
      tap_reg.ones_cnt <= 3'h0;
    end
    else
    begin
      tap_reg <= tap_next;
    end
  end

  assign state_o = tap_reg.tap;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_leave_reset;
    tck_rise_i && !tms_i && state_o == bstl_pkg::BSTL_TLR;
  endsequence

  property p_five_ones;
    tap_reg.ones_cnt == `BSTL_TMS_RESET_COUNT |-> state_o == bstl_pkg::BSTL_TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("tms high five edges did not reach reset");

  property p_leave_reset;
    s_leave_reset |=> state_o == bstl_pkg::BSTL_RTI;
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("reset state did not go to idle");

  property p_hold_between;
    !tck_rise_i |=> state_o == $past(state_o);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("state moved without a test clock edge");

endmodule

`default_nettype wire

/* File: bstl_top.sv */
// Boundary-scan test logic: sampling, registers and pad control
`include "bstl_defs.svh"
`default_nettype none

// Operation
// - A one-bit bypass register sits between tdi and tdo whenever no other data register is selected.
// - Power-up reset puts the test logic in reset with the bypass instruction loaded.
// - Boundary cells sit at the host bus pads and serial memory pads to control and observe them.
// - Output-enable cells exist for the two-way pads and, under EXTEST, a 1 in them drives the pads from cells.
// - The chain runs from tdi through the bus pads, serial memory pads, internal cells and boot address cells to tdo.
// - Eleven internal cells follow the serial memory clock cell in order 0-6, 9, 7, 8, 10.
// - The controller decodes tms with the full sixteen-state machine on the test clock.
// - The controller produces the capture, shift and update strobes of all registers.
// - A three-bit instruction register is loaded through the scan path and decoded.
// - Code 000 is EXTEST, 001 sample-preload, 111 bypass; 010, 011 and 100 are reserved.
// - Code 101 floats the bus pads by clearing all nine output enables; code 110 selects the continuity test.
module bstl_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Test port
  input wire bstl_pkg::bstl_link_s link_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Pad observe and system values, in chain order
  input wire logic [`BSTL_CHAIN_LEN-1:0] cell_capture_i,
  input wire logic [`BSTL_CHAIN_LEN-1:0] sys_out_i,
  input wire logic [`BSTL_OE_GROUPS-1:0] sys_oe_i,
  // Pad drive
  output logic [`BSTL_CHAIN_LEN-1:0] pad_out_o,
  output logic [`BSTL_OE_GROUPS-1:0] pad_oe_o,
  // Mode status
  output logic continuity_test_o
);

  bstl_pkg::bstl_core_s core_reg;
  bstl_pkg::bstl_core_s core_next;
  bstl_pkg::bstl_tap_e tap_state;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic bsr_sel;
  logic extest;
  logic float_pads;

  // Boundary register is the data register only for EXTEST and sample-preload
  function automatic logic bsr_selected(input logic [`BSTL_IR_WIDTH-1:0] code);
    bsr_selected = (code == `BSTL_IR_EXTEST) || (code == `BSTL_IR_SAMPLE);
  endfunction

  // Chain position of each output-enable cell
  function automatic logic [6:0] oe_cell(input int grp);
    case (grp)
      0: oe_cell = `BSTL_CELL_AD_OE;
      1: oe_cell = `BSTL_CELL_CBE_OE;
      2: oe_cell = `BSTL_CELL_FRAME_OE;
      3: oe_cell = `BSTL_CELL_IRDY_OE;
      4: oe_cell = `BSTL_CELL_TRDY_OE;
      5: oe_cell = `BSTL_CELL_DEVSEL_OE;
      6: oe_cell = `BSTL_CELL_STOP_OE;
      7: oe_cell = `BSTL_CELL_PERR_OE;
      default: oe_cell = `BSTL_CELL_PAR_OE;
    endcase
  endfunction

  assign tck_rise = core_reg.sync2.tck & ~core_reg.tck_prev;
  assign tck_fall = ~core_reg.sync2.tck & core_reg.tck_prev;
  assign tms_s = core_reg.sync2.tms;
  assign tdi_s = core_reg.sync2.tdi;
  assign bsr_sel = bsr_selected(core_reg.instruction_code);

  bstl_tap_fsm u_tap (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .tck_rise_i(tck_rise),
    .tms_i(tms_s),
    .state_o(tap_state)
  );

  always_comb
  begin
    core_next = core_reg;
    core_next.sync1 = link_i;
    core_next.sync2 = core_reg.sync1;
    core_next.tck_prev = core_reg.sync2.tck;
    // Capture and shift on the test clock rising edge
    if (tck_rise)
    begin
      case (tap_state)
        bstl_pkg::BSTL_CAPDR:
        begin
          if (bsr_sel)
          begin
            core_next.chain = cell_capture_i;
          end
          else
          begin
            core_next.byp = 1'b0;
          end
        end
        bstl_pkg::BSTL_SHDR:
        begin
          if (bsr_sel)
          begin
            core_next.chain = {core_reg.chain[`BSTL_CHAIN_LEN-2:0], tdi_s};
          end
          else
          begin
            core_next.byp = tdi_s;
          end
        end
        bstl_pkg::BSTL_CAPIR:
        begin
          core_next.ir_sr = `BSTL_IR_CAPTURE;
        end
        bstl_pkg::BSTL_SHIR:
        begin
          core_next.ir_sr = {tdi_s, core_reg.ir_sr[`BSTL_IR_WIDTH-1:1]};
        end
        default:
        begin
          core_next.byp = core_reg.byp;
        end
      endcase
    end
    // Output and update on the test clock falling edge
    if (tck_fall)
    begin
      core_next.tdo_oe = (tap_state == bstl_pkg::BSTL_SHDR) || (tap_state == bstl_pkg::BSTL_SHIR);
      if (tap_state == bstl_pkg::BSTL_SHIR)
      begin
        core_next.tdo = core_reg.ir_sr[0];
      end
      else if (bsr_sel)
      begin
        core_next.tdo = core_reg.chain[`BSTL_CHAIN_LEN-1];
      end
      else
      begin
        core_next.tdo = core_reg.byp;
      end
      if (tap_state == bstl_pkg::BSTL_UPDR && bsr_sel)
      begin
        core_next.upd = core_reg.chain;
      end
      if (tap_state == bstl_pkg::BSTL_UPIR)
      begin
        core_next.instruction_code = core_reg.ir_sr;
      end
    end
    // Reset state always selects bypass
    if (tap_state == bstl_pkg::BSTL_TLR)
    begin
      core_next.instruction_code = `BSTL_IR_BYPASS;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      core_reg <= '0;
      core_reg.instruction_code <= `BSTL_IR_BYPASS;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign extest = core_reg.instruction_code == `BSTL_IR_EXTEST;
  assign float_pads = core_reg.instruction_code == `BSTL_IR_HIGHZ;
  assign continuity_test_o = core_reg.instruction_code == `BSTL_IR_CONTINUITY;
  assign tdo_o = core_reg.tdo;
  assign tdo_oe_o = core_reg.tdo_oe;
  assign pad_out_o = extest ? core_reg.upd : sys_out_i;

  always_comb
  begin
    for (int g = 0; g < `BSTL_OE_GROUPS; g++)
    begin
      if (float_pads)
      begin
        pad_oe_o[g] = 1'b0;
      end
      else if (extest)
      begin
        pad_oe_o[g] = core_reg.upd[oe_cell(g)];
      end
      else
      begin
        pad_oe_o[g] = sys_oe_i[g];
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_byp_capture;
    tck_rise && tap_state == bstl_pkg::BSTL_CAPDR && !bsr_sel;
  endsequence

  sequence s_bsr_shift;
    tck_rise && tap_state == bstl_pkg::BSTL_SHDR && bsr_sel;
  endsequence

  property p_rst_bypass;
    $past(sys_rst_i) |-> core_reg.instruction_code == `BSTL_IR_BYPASS;
  endproperty
  a_rst_bypass: assert property (p_rst_bypass) else $error("bypass not loaded after reset");

  property p_tlr_bypass;
    tap_state == bstl_pkg::BSTL_TLR |=> core_reg.instruction_code == `BSTL_IR_BYPASS;
  endproperty
  a_tlr_bypass: assert property (p_tlr_bypass) else $error("reset state left a non-bypass code");

  property p_byp_capture;
    s_byp_capture |=> !core_reg.byp;
  endproperty
  a_byp_capture: assert property (p_byp_capture) else $error("bypass did not capture zero");

  property p_byp_to_tdo;
    tck_fall && tap_state == bstl_pkg::BSTL_SHDR && !bsr_sel |=> tdo_o == $past(core_reg.byp) && tdo_oe_o;
  endproperty
  a_byp_to_tdo: assert property (p_byp_to_tdo) else $error("bypass bit not on tdo");

  property p_bsr_shift;
    s_bsr_shift |=> core_reg.chain == {$past(core_reg.chain[`BSTL_CHAIN_LEN-2:0]), $past(tdi_s)};
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("boundary chain shift wrong");

  property p_ir_update;
    tck_fall && tap_state == bstl_pkg::BSTL_UPIR |=> core_reg.instruction_code == $past(core_reg.ir_sr);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

  property p_extest_oe;
    extest |-> pad_oe_o[0] == core_reg.upd[`BSTL_CELL_AD_OE] && pad_out_o == core_reg.upd;
  endproperty
  a_extest_oe: assert property (p_extest_oe) else $error("extest pad drive wrong");

  property p_float;
    core_reg.instruction_code == `BSTL_IR_HIGHZ |-> pad_oe_o == '0;
  endproperty
  a_float: assert property (p_float) else $error("pads not floated");

endmodule

`default_nettype wire

/* File: bstl_jtag_master.sv */
// Board test controller model that drives the scan link
`include "bstl_defs.svh"
`default_nettype none

module bstl_jtag_master (
  // Link to the device
  output var bstl_pkg::bstl_link_s link_o,
  // Test data out of the device
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = `BSTL_CHAIN_LEN;

  initial link_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

  // One test clock period; tdo is taken just before the falling edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    #9;
    link_o.tms = tms;
    link_o.tdi = tdi;
    #84 link_o.tck = 1'b1;
    #97 tdo = tdo_i;
    #1 link_o.tck = 1'b0;
    #9;
  endtask

  // Five tms highs reach reset, then one low parks in idle
  task automatic go_reset();
    logic x;
    repeat (5) tick(1'b1, ~link_o.tdi, x);
    tick(1'b0, ~link_o.tdi, x);
  endtask

  // Scan from idle back to idle; tdi toggles while no data is shifted
  task automatic scan(input logic ir, input int n, input logic [L-1:0] d, output logic [L-1:0] q,
    output logic oe);
    logic x;
    q = '0;
    oe = 1'b1;
    tick(1'b1, ~link_o.tdi, x);
    if (ir)
      tick(1'b1, ~link_o.tdi, x);
    tick(1'b0, ~link_o.tdi, x);
    tick(1'b0, ~link_o.tdi, x);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i], q[i]);
      if (i < n - 1)
        oe &= tdo_oe_i;
    end
    tick(1'b1, ~link_o.tdi, x);
    tick(1'b0, ~link_o.tdi, x);
  endtask
endmodule

`default_nettype wire

/* File: boundary_scan_test_logic_tb.sv */
// Self-checking bench of the boundary-scan test logic
`include "bstl_defs.svh"
`default_nettype none

module boundary_scan_test_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = `BSTL_CHAIN_LEN;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  bstl_pkg::bstl_link_s link;
  logic tdo, tdo_oe, cont, oe;
  logic [L-1:0] cap = '0, sys_out = '0, pad_out, q, d, r;
  logic [L-1:0] pat = 75'h6A3C71E96D24B0F81E5;
  logic [8:0] sys_oe = '0, pad_oe;
  int n_errors = 0;
  int total_checks = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  bstl_top u_bstl_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .link_i(link), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .cell_capture_i(cap), .sys_out_i(sys_out), .sys_oe_i(sys_oe),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .continuity_test_o(cont));
  bstl_jtag_master u_bstl_jtag_master (.link_o(link), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  task automatic check(input logic [L-1:0] seen, input logic [L-1:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [8:0] oe_of(input logic [L-1:0] v);
    return {v[`BSTL_CELL_PAR_OE], v[`BSTL_CELL_PERR_OE], v[`BSTL_CELL_STOP_OE], v[`BSTL_CELL_DEVSEL_OE],
      v[`BSTL_CELL_TRDY_OE], v[`BSTL_CELL_IRDY_OE], v[`BSTL_CELL_FRAME_OE], v[`BSTL_CELL_CBE_OE],
      v[`BSTL_CELL_AD_OE]};
  endfunction

  task automatic load_ir(input logic [2:0] code);
    u_bstl_jtag_master.scan(1'b1, 3, {72'h0, code}, q, oe);
    repeat (10) @(posedge core_clk_i);
  endtask

  // Bypass data path is one bit long
  task automatic bypass_len();
    u_bstl_jtag_master.scan(1'b0, 2, 75'h3, q, oe);
    check(q[1:0], 2'h2, "one-bit data path");
  endtask

  task automatic t_reset();
    check(pad_out, sys_out, "pads after reset");
    check(pad_oe, sys_oe, "enables after reset");
    check(tdo_oe, 1'b0, "tdo idle");
    u_bstl_jtag_master.scan(1'b0, 4, 75'hA, q, oe);
    check(q[3:0], 4'h4, "bypass delay");
    $display("test reset done");
  endtask

  task automatic t_codes();
    for (int c = 2; c < 8; c++)
    begin
      load_ir(c[2:0]);
      check(q[2:0], `BSTL_IR_CAPTURE, "instruction capture");
      check(pad_oe, c == 5 ? 9'h0 : sys_oe, "enables per code");
      check(cont, c == 6, "continuity flag");
      check(pad_out, sys_out, "pads per code");
      bypass_len();
      check(oe, 1'b1, "tdo driven in shift");
    end
    $display("test codes done");
  endtask

  task automatic t_preload();
    load_ir(`BSTL_IR_SAMPLE);
    d = {<<{pat}};
    u_bstl_jtag_master.scan(1'b0, L, d, q, oe);
    r = {<<{q}};
    check(r, cap, "captured chain");
    check(oe, 1'b1, "tdo driven in shift");
    repeat (10) @(posedge core_clk_i);
    check(pad_out, sys_out, "pads in sample");
    $display("test preload done");
  endtask

  task automatic t_extest();
    load_ir(`BSTL_IR_EXTEST);
    check(pad_out, pat, "preloaded pads");
    check(pad_oe, oe_of(pat), "preloaded enables");
    d = {<<{~pat}};
    u_bstl_jtag_master.scan(1'b0, L, d, q, oe);
    r = {<<{q}};
    check(r, cap, "extest capture");
    repeat (10) @(posedge core_clk_i);
    check(pad_out, ~pat, "updated pads");
    check(pad_oe, oe_of(~pat), "updated enables");
    $display("test extest done");
  endtask

  task automatic t_tms_reset();
    u_bstl_jtag_master.go_reset();
    repeat (4) @(posedge core_clk_i);
    check(pad_out, sys_out, "pads after tms reset");
    check(pad_oe, sys_oe, "enables after tms reset");
    bypass_len();
    $display("test tms reset done");
  endtask

  // Instruction load through the pause states, then a reset in mid-run
  task automatic t_pause();
    logic x;
    q = '0;
    u_bstl_jtag_master.tick(1'b1, 1'b0, x);
    u_bstl_jtag_master.tick(1'b1, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, q[0]);
    u_bstl_jtag_master.tick(1'b1, 1'b1, q[1]);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    u_bstl_jtag_master.tick(1'b1, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    u_bstl_jtag_master.tick(1'b1, 1'b1, q[2]);
    u_bstl_jtag_master.tick(1'b1, 1'b0, x);
    u_bstl_jtag_master.tick(1'b0, 1'b0, x);
    repeat (2) @(posedge core_clk_i);
    check(q[2:0], `BSTL_IR_CAPTURE, "capture across pause");
    check(cont, 1'b1, "continuity via pause states");
    check(pad_oe, sys_oe, "enables in continuity");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    check(cont, 1'b0, "bypass after mid-run reset");
    check(tdo_oe, 1'b0, "tdo idle after mid-run reset");
    u_bstl_jtag_master.go_reset();
    bypass_len();
    $display("test pause done");
  endtask

  initial
  begin
    #2ms;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    sys_out <= 75'h2B7E1516628AED2A6AB;
    sys_oe <= 9'h15A;
    cap <= 75'h3C4FCF4F3C762E7160F;
    repeat (2) @(posedge core_clk_i);
    u_bstl_jtag_master.go_reset();
    t_reset();
    t_codes();
    t_preload();
    t_extest();
    t_tms_reset();
    t_pause();
    give_verdict();
  end
endmodule

`default_nettype wire
